// ==== rtl/tmc_pkg.sv ====
/*
 * tmc_pkg: constants of the timer counter / modulo control core.
 * assumes byte registers on a plain address/strobe port, one bus clock.
 */
package tmc_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [2:0] TMC_ADDR_SC    = 3'h0;
	localparam logic [2:0] TMC_ADDR_CNTH  = 3'h1;
	localparam logic [2:0] TMC_ADDR_CNTL  = 3'h2;
	localparam logic [2:0] TMC_ADDR_MODH  = 3'h3;
	localparam logic [2:0] TMC_ADDR_MODL  = 3'h4;
	// ------------------------------------------------------------
	// status/control fields
	// ------------------------------------------------------------
	localparam int TMC_SC_OVF_BIT  = 7;
	localparam int TMC_SC_IRQE_BIT = 6;
	localparam int TMC_SC_CAS_BIT  = 5;
	localparam int TMC_SC_CLK_HI   = 4;
	localparam int TMC_SC_CLK_LO   = 3;
	localparam int TMC_SC_PS_HI    = 2;
	localparam int TMC_SC_PS_LO    = 0;
	// ------------------------------------------------------------
	// values
	// ------------------------------------------------------------
	localparam logic [1:0]  TMC_CLK_NONE  = 2'h0;
	localparam logic [1:0]  TMC_CLK_BUS   = 2'h1;
	localparam logic [1:0]  TMC_CLK_FIXED = 2'h2;
	localparam logic [1:0]  TMC_CLK_EXT   = 2'h3;
	localparam logic [15:0] TMC_CNT_ZERO  = 16'h0000;
	localparam logic [15:0] TMC_CNT_FULL  = 16'hffff;
	localparam logic [15:0] TMC_CNT_FULLM1 = 16'hfffe;
	localparam logic [15:0] TMC_CNT_ONE   = 16'h0001;
	localparam logic [7:0]  TMC_BYTE_ZERO = 8'h00;
	localparam logic [6:0]  TMC_PS_ZERO   = 7'h00;
	localparam logic [6:0]  TMC_PS_ONE    = 7'h01;

	typedef enum logic [1:0] {
		TMC_LATCH_IDLE,
		TMC_LATCH_HIGH,
		TMC_LATCH_LOW
	} tmc_latch_type;
endpackage : tmc_pkg

// ==== rtl/tmc_core.sv ====
/*
 * tmc_core: shared counter, modulo and status/control core of a timer unit.
 * assumes byte register port with read data one cycle after the read strobe,
 * external and fixed count clocks arriving asynchronously.
 */
`timescale 1ns/1ps
module tmc_core
	import tmc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        clk_en_i,
	input  wire logic [2:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic        debug_halt_mode_i,
	input  wire logic        fixed_count_clock_i,
	input  wire logic        external_count_clock_i,
	output logic      [7:0]  rdata_o,
	output logic             overflow_irq_o,
	output logic      [15:0] count_value_o,
	output logic             count_down_o,
	output logic             center_align_select_o
);
	// ------------------------------------------------------------
	// synchronisers and edge detect
	// ------------------------------------------------------------
	logic [1:0] fix_sync_q, fix_sync_d, ext_sync_q, ext_sync_d;
	logic       fix_prev_q, fix_prev_d, ext_prev_q, ext_prev_d;
	logic       halt_s1_q, halt_s1_d, halt_q, halt_d;

	always_comb begin
		fix_sync_d = {fix_sync_q[0], fixed_count_clock_i};
		ext_sync_d = {ext_sync_q[0], external_count_clock_i};
		fix_prev_d = fix_sync_q[1];
		ext_prev_d = ext_sync_q[1];
		halt_s1_d  = debug_halt_mode_i;
		halt_d     = halt_s1_q;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			fix_sync_q <= 2'h0;
			ext_sync_q <= 2'h0;
			fix_prev_q <= 1'b0;
			ext_prev_q <= 1'b0;
			halt_s1_q  <= 1'b0;
			halt_q     <= 1'b0;
		end else if (clk_en_i) begin
			fix_sync_q <= fix_sync_d;
			ext_sync_q <= ext_sync_d;
			fix_prev_q <= fix_prev_d;
			ext_prev_q <= ext_prev_d;
			halt_s1_q  <= halt_s1_d;
			halt_q     <= halt_d;
		end
	end

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic        ovf_q, ovf_d, armed_q, armed_d;
	logic        irqe_q, irqe_d, cas_q, cas_d;
	logic [1:0]  clks_q, clks_d;
	logic [2:0]  ps_q, ps_d;
	logic [15:0] cnt_q, cnt_d, mod_q, mod_d, modbuf_q, modbuf_d;
	logic        down_q, down_d;
	logic [6:0]  pre_q, pre_d;
	logic [7:0]  rdbuf_q, rdbuf_d, rdata_d;
	tmc_latch_type cnt_lat_q, cnt_lat_d, mod_lat_q, mod_lat_d;
	logic        mod_pend_q, mod_pend_d, irq_d;

	function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
		hit = (a == r);
	endfunction : hit

	logic        wr_sc, wr_cnt, wr_mod, rd_sc, rd_cnt, src_tick, tick;
	logic        free_run;
	logic [15:0] top;
	logic [6:0]  ps_mask;

	always_comb begin
		wr_sc  = wr_i && hit(addr_i, TMC_ADDR_SC);
		wr_cnt = wr_i && (hit(addr_i, TMC_ADDR_CNTH) || hit(addr_i, TMC_ADDR_CNTL));
		wr_mod = wr_i && (hit(addr_i, TMC_ADDR_MODH) || hit(addr_i, TMC_ADDR_MODL));
		rd_sc  = rd_i && hit(addr_i, TMC_ADDR_SC);
		rd_cnt = rd_i && (hit(addr_i, TMC_ADDR_CNTH) || hit(addr_i, TMC_ADDR_CNTL));
		case (clks_q)
			TMC_CLK_NONE:  src_tick = 1'b0;
			TMC_CLK_BUS:   src_tick = 1'b1;
			TMC_CLK_FIXED: src_tick = fix_sync_q[1] && !fix_prev_q;
			TMC_CLK_EXT:   src_tick = ext_sync_q[1] && !ext_prev_q;
			default:       src_tick = 1'b0;
		endcase
		// prescaler counts after source selection, mask read live from ps_q
		ps_mask = 7'((8'h01 << ps_q) - 8'h01);
		tick    = src_tick && ((pre_q & ps_mask) == ps_mask) && !halt_q;
		free_run = (mod_q == TMC_CNT_ZERO) || (mod_q == TMC_CNT_FULL);
		top      = free_run ? TMC_CNT_FULL : mod_q;
	end

	// ------------------------------------------------------------
	// counter, prescaler, modulo
	// ------------------------------------------------------------
	always_comb begin
		cnt_d      = cnt_q;
		down_d     = down_q;
		pre_d      = pre_q;
		mod_d      = mod_q;
		modbuf_d   = modbuf_q;
		mod_lat_d  = mod_lat_q;
		mod_pend_d = mod_pend_q;
		// leaving center mode drops the direction even with no clock selected
		if (!cas_q)
			down_d = 1'b0;
		if (src_tick && !halt_q)
			pre_d = 7'(pre_q + TMC_PS_ONE) & ps_mask;
		if (tick) begin
			if (cas_q && !free_run) begin
				if (!down_q) begin
					if (cnt_q >= top) begin
						down_d = 1'b1;
						cnt_d  = 16'(cnt_q - TMC_CNT_ONE);
					end else begin
						cnt_d = 16'(cnt_q + TMC_CNT_ONE);
					end
				end else if (cnt_q == TMC_CNT_ZERO) begin
					down_d = 1'b0;
					cnt_d  = TMC_CNT_ONE;
				end else begin
					cnt_d = 16'(cnt_q - TMC_CNT_ONE);
				end
			end else begin
				down_d = 1'b0;
				cnt_d = (cnt_q >= top) ? TMC_CNT_ZERO : 16'(cnt_q + TMC_CNT_ONE);
			end
			// buffered modulo lands on the step into the old top
			if (mod_pend_q && (16'(cnt_q + TMC_CNT_ONE) == top)) begin
				mod_d      = modbuf_q;
				mod_pend_d = 1'b0;
			end
		end
		if (wr_cnt) begin
			cnt_d  = TMC_CNT_ZERO;
			down_d = 1'b0;
			pre_d  = TMC_PS_ZERO;
		end
		if (wr_mod) begin
			if (halt_q) begin
				if (hit(addr_i, TMC_ADDR_MODH))
					mod_d[15:8] = wdata_i;
				else
					mod_d[7:0] = wdata_i;
			end else begin
				if (hit(addr_i, TMC_ADDR_MODH))
					modbuf_d[15:8] = wdata_i;
				else
					modbuf_d[7:0] = wdata_i;
				case (mod_lat_q)
					TMC_LATCH_IDLE: mod_lat_d = hit(addr_i, TMC_ADDR_MODH) ?
						TMC_LATCH_HIGH : TMC_LATCH_LOW;
					TMC_LATCH_HIGH, TMC_LATCH_LOW: begin
						mod_lat_d = TMC_LATCH_IDLE;
						if (clks_q == TMC_CLK_NONE) begin
							mod_d = modbuf_d;
							mod_pend_d = 1'b0;
						end else begin
							mod_pend_d = 1'b1;
						end
					end
					default: mod_lat_d = TMC_LATCH_IDLE;
				endcase
			end
		end
		if (wr_sc)
			mod_lat_d = TMC_LATCH_IDLE;
	end

	// ------------------------------------------------------------
	// status/control and read coherency
	// ------------------------------------------------------------
	logic wrap_evt;
	always_comb begin
		// overflow: counter returns to zero from top (up mode) or turns at zero
		wrap_evt = tick && !wr_cnt && (cas_q && !free_run ?
			(down_q && cnt_q == TMC_CNT_ZERO) : (cnt_q >= top));
		ovf_d   = ovf_q;
		armed_d = armed_q;
		irqe_d  = irqe_q;
		cas_d   = cas_q;
		clks_d  = clks_q;
		ps_d    = ps_q;
		if (rd_sc && ovf_q)
			armed_d = 1'b1;
		if (wr_sc) begin
			irqe_d = wdata_i[TMC_SC_IRQE_BIT];
			cas_d  = wdata_i[TMC_SC_CAS_BIT];
			clks_d = wdata_i[TMC_SC_CLK_HI:TMC_SC_CLK_LO];
			ps_d   = wdata_i[TMC_SC_PS_HI:TMC_SC_PS_LO];
			// writing one leaves the flag alone
			if (!wdata_i[TMC_SC_OVF_BIT] && armed_q)
				ovf_d = 1'b0;
			armed_d = 1'b0;
		end
		// set beats clear unless a modulo write is half done (then the overflow is lost); a fresh overflow also drops a half-done clear
		if (wrap_evt && mod_lat_q == TMC_LATCH_IDLE) begin
			ovf_d   = 1'b1;
			armed_d = 1'b0;
		end
		irq_d = irqe_d && ovf_d && (mod_lat_d == TMC_LATCH_IDLE);
	end

	always_comb begin
		cnt_lat_d = cnt_lat_q;
		rdbuf_d   = rdbuf_q;
		rdata_d   = TMC_BYTE_ZERO;
		if (rd_cnt && !halt_q) begin
			case (cnt_lat_q)
				TMC_LATCH_IDLE: begin
					cnt_lat_d = hit(addr_i, TMC_ADDR_CNTH) ? TMC_LATCH_HIGH : TMC_LATCH_LOW;
					rdbuf_d   = hit(addr_i, TMC_ADDR_CNTH) ? cnt_q[7:0] : cnt_q[15:8];
				end
				TMC_LATCH_HIGH: if (hit(addr_i, TMC_ADDR_CNTL)) cnt_lat_d = TMC_LATCH_IDLE;
				TMC_LATCH_LOW:  if (hit(addr_i, TMC_ADDR_CNTH)) cnt_lat_d = TMC_LATCH_IDLE;
				default: cnt_lat_d = TMC_LATCH_IDLE;
			endcase
		end
		if (wr_sc || wr_cnt)
			cnt_lat_d = TMC_LATCH_IDLE;
		if (rd_i) begin
			case (addr_i)
				TMC_ADDR_SC:   rdata_d = {ovf_q, irqe_q, cas_q, clks_q, ps_q};
				TMC_ADDR_CNTH: rdata_d = (cnt_lat_q == TMC_LATCH_LOW) ? rdbuf_q : cnt_q[15:8];
				TMC_ADDR_CNTL: rdata_d = (cnt_lat_q == TMC_LATCH_HIGH) ? rdbuf_q : cnt_q[7:0];
				TMC_ADDR_MODH: rdata_d = mod_q[15:8];
				TMC_ADDR_MODL: rdata_d = mod_q[7:0];
				default:       rdata_d = TMC_BYTE_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ovf_q      <= 1'b0;
			armed_q    <= 1'b0;
			irqe_q     <= 1'b0;
			cas_q      <= 1'b0;
			clks_q     <= TMC_CLK_NONE;
			ps_q       <= 3'h0;
			cnt_q      <= TMC_CNT_ZERO;
			down_q     <= 1'b0;
			pre_q      <= TMC_PS_ZERO;
			mod_q      <= TMC_CNT_ZERO;
			modbuf_q   <= TMC_CNT_ZERO;
			mod_lat_q  <= TMC_LATCH_IDLE;
			mod_pend_q <= 1'b0;
			cnt_lat_q  <= TMC_LATCH_IDLE;
			rdbuf_q    <= TMC_BYTE_ZERO;
			rdata_o    <= TMC_BYTE_ZERO;
			overflow_irq_o <= 1'b0;
		end else if (clk_en_i) begin
			ovf_q      <= ovf_d;
			armed_q    <= armed_d;
			irqe_q     <= irqe_d;
			cas_q      <= cas_d;
			clks_q     <= clks_d;
			ps_q       <= ps_d;
			cnt_q      <= cnt_d;
			down_q     <= down_d;
			pre_q      <= pre_d;
			mod_q      <= mod_d;
			modbuf_q   <= modbuf_d;
			mod_lat_q  <= mod_lat_d;
			mod_pend_q <= mod_pend_d;
			cnt_lat_q  <= cnt_lat_d;
			rdbuf_q    <= rdbuf_d;
			rdata_o    <= rdata_d;
			overflow_irq_o <= irq_d;
		end
	end

	// channel-facing copies, registered from the next-state values so they match the core registers in the same cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			count_value_o         <= TMC_CNT_ZERO;
			count_down_o          <= 1'b0;
			center_align_select_o <= 1'b0;
		end else if (clk_en_i) begin
			count_value_o         <= cnt_d;
			count_down_o          <= down_d;
			center_align_select_o <= cas_d;
		end
	end
endmodule : tmc_core

// ==== tb/tmc_core_chk.sv ====
/*
 * tmc_core_chk: port-level assertions for the timer counter core.
 * assumes bind to tmc_core; bench keeps one idle cycle after each strobe.
 */
`timescale 1ns/1ps
module tmc_core_chk
	import tmc_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic        clk_en_i,
	input wire logic [2:0]  addr_i,
	input wire logic [7:0]  wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic        debug_halt_mode_i,
	input wire logic        fixed_count_clock_i,
	input wire logic        external_count_clock_i,
	input wire logic [7:0]  rdata_o,
	input wire logic        overflow_irq_o,
	input wire logic [15:0] count_value_o,
	input wire logic        count_down_o,
	input wire logic        center_align_select_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ------------------------------------------------------------
	// register port
	// ------------------------------------------------------------
	a_rd_idle: assert property ($past(clk_en_i) && !$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not idle");
	a_unmapped_zero: assert property (rd_i && clk_en_i && addr_i > 3'h4 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_sc_fields: assert property ((wr_i && clk_en_i && addr_i == TMC_ADDR_SC) ##2
		(rd_i && clk_en_i && addr_i == TMC_ADDR_SC) |=> rdata_o[4:0] == $past(wdata_i[4:0], 3))
		else $error("control field readback wrong");
	a_center_mirror: assert property (wr_i && clk_en_i && addr_i == TMC_ADDR_SC
		|=> center_align_select_o == $past(wdata_i[TMC_SC_CAS_BIT])) else $error("center out");
	a_center_read: assert property (rd_i && clk_en_i && addr_i == TMC_ADDR_SC
		|=> rdata_o[TMC_SC_CAS_BIT] == center_align_select_o) else $error("center read");
	// ------------------------------------------------------------
	// counter and interrupt
	// ------------------------------------------------------------
	a_cnt_wr_clr: assert property (wr_i && clk_en_i && (addr_i == TMC_ADDR_CNTH ||
		addr_i == TMC_ADDR_CNTL) |=> count_value_o == TMC_CNT_ZERO) else $error("no clear");
	a_irq_off: assert property (wr_i && clk_en_i && addr_i == TMC_ADDR_SC &&
		!wdata_i[TMC_SC_IRQE_BIT] |-> ##[1:2] !overflow_irq_o) else $error("irq stays");
	a_halt_freeze: assert property (debug_halt_mode_i [*5] ##0 !wr_i
		|=> $stable(count_value_o)) else $error("counter moved in halt");
	a_up_step: assert property (!center_align_select_o && $past(!center_align_select_o) &&
		count_value_o != $past(count_value_o) |-> count_value_o == $past(count_value_o)
		+ 16'h0001 || count_value_o == TMC_CNT_ZERO) else $error("bad up step");
	a_down_center: assert property (!center_align_select_o [*3] |-> !count_down_o)
		else $error("down without center");
endmodule : tmc_core_chk

bind tmc_core tmc_core_chk u_tmc_core_chk (.*);

// ==== tb/testbench.sv ====
/*
 * testbench: directed scenarios for the timer counter core.
 * assumes 40 MHz bus clock, slow count clocks derived from a cycle count.
 */
`timescale 1ns/1ps
module testbench
	import tmc_pkg::*;
;
	logic        clock_i, rst_n_i, clk_en_i, wr_i, rd_i, debug_halt_mode_i;
	logic        fixed_count_clock_i = 0, external_count_clock_i = 0;
	logic [2:0]  addr_i;
	logic [7:0]  wdata_i, rdata_o, v;
	logic [15:0] count_value_o, c0;
	logic        overflow_irq_o, count_down_o, center_align_select_o;
	int          errors, n_tests, n, cyc = 0;

	tmc_core u_tmc_core (.clk_i(clock_i), .rst_n_i, .clk_en_i, .addr_i, .wdata_i, .wr_i,
		.rd_i, .debug_halt_mode_i, .fixed_count_clock_i, .external_count_clock_i, .rdata_o,
		.overflow_irq_o, .count_value_o, .count_down_o, .center_align_select_o);

	initial begin
		clock_i = 0;
		forever #12.5 clock_i = ~clock_i;
	end
	// slow sources: fixed at bus/8, external at bus/16 (under a quarter of bus rate)
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		fixed_count_clock_i <= cyc[2];
		external_count_clock_i <= cyc[3];
		if (cyc == 40000) begin
			errors++;
			results();
		end
	end
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic tick();
		@(posedge clock_i);
		#1;
	endtask : tick
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		tick();
		wr_i <= 1'b0;
		tick();
	endtask : wr
	task automatic rd(input logic [2:0] a);
		addr_i <= a;
		rd_i <= 1'b1;
		tick();
		rd_i <= 1'b0;
		v = rdata_o;
		tick();
	endtask : rd
	// ticks from the call until the next change (at most 400) end up in n
	task automatic until_chg();
		c0 = count_value_o;
		n = 0;
		while (count_value_o === c0 && n < 400) begin
			tick();
			n++;
		end
	endtask : until_chg
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rd(TMC_ADDR_SC);
		chk(v, 8'h00);
		rd(TMC_ADDR_MODH);
		chk(v, 8'h00);
		rd(TMC_ADDR_MODL);
		chk(v, 8'h00);
		rd(3'h5);
		chk(v, 8'h00);
		chk(count_value_o, 16'h0000);
	endtask : t_reset
	logic [7:0]  n_sel [3] = '{8'h10, 8'h18, 8'h00};
	logic [15:0] n_lo [3] = '{16'h0020, 16'h0010, 16'h0000};
	task automatic t_src();
		foreach (n_sel[i]) begin
			wr(TMC_ADDR_SC, n_sel[i]);
			c0 = count_value_o;
			repeat (256) tick();
			c0 = count_value_o - c0;
			chk(16'(c0 + 16'h0001 >= n_lo[i] && c0 <= n_lo[i] + 16'h0001), 16'h0001);
		end
		wr(TMC_ADDR_CNTH, 8'hff);
		chk(count_value_o, 16'h0000);
	endtask : t_src
	task automatic t_mod();
		wr(TMC_ADDR_MODH, 8'h00);
		wr(TMC_ADDR_MODL, 8'h09);
		wr(TMC_ADDR_SC, 8'h08);
		for (n = 0; count_value_o !== 16'h0009 && n < 100; n++) tick();
		tick();
		chk(count_value_o, 16'h0000);
		rd(TMC_ADDR_SC);
		chk(v[7], 1'b1);
		repeat (12) tick();
		wr(TMC_ADDR_SC, 8'h0f);
		rd(TMC_ADDR_SC);
		chk(v, 8'h8f);
		wr(TMC_ADDR_SC, 8'h4f);
		rd(TMC_ADDR_SC);
		chk(v, 8'h4f);
		wr(TMC_ADDR_SC, 8'hcf);
		rd(TMC_ADDR_SC);
		chk(v, 8'h4f);
		for (n = 0; overflow_irq_o !== 1'b1 && n < 1400; n++) tick();
		chk(overflow_irq_o, 1'b1);
		wr(TMC_ADDR_SC, 8'h0f);
		tick();
		chk(overflow_irq_o, 1'b0);
	endtask : t_mod
	task automatic t_ps();
		for (int p = 0; p < 8; p++) begin
			wr(TMC_ADDR_SC, 8'h08 | 8'(p));
			until_chg();
			until_chg();
			until_chg();
			chk(16'(n), 16'(1 << p));
		end
	endtask : t_ps
	task automatic t_coh();
		until_chg();
		c0 = count_value_o;
		rd(TMC_ADDR_CNTH);
		until_chg();
		rd(TMC_ADDR_CNTL);
		chk(v, c0[7:0]);
		rd(TMC_ADDR_CNTH);
		wr(TMC_ADDR_SC, 8'h0f);
		until_chg();
		c0 = count_value_o;
		rd(TMC_ADDR_CNTL);
		chk(v, c0[7:0]);
		debug_halt_mode_i <= 1'b1;
		repeat (4) tick();
		c0 = count_value_o;
		repeat (300) tick();
		chk(count_value_o, c0);
		wr(TMC_ADDR_MODL, 8'h07);
		rd(TMC_ADDR_MODL);
		chk(v, 8'h07);
		debug_halt_mode_i <= 1'b0;
	endtask : t_coh
	task automatic t_center();
		wr(TMC_ADDR_CNTL, 8'h00);
		wr(TMC_ADDR_SC, 8'h28);
		for (n = 0; count_down_o !== 1'b1 && n < 40; n++) tick();
		chk(count_down_o, 1'b1);
		chk(center_align_select_o, 1'b1);
		clk_en_i <= 1'b0;
		tick();
		c0 = count_value_o;
		repeat (20) tick();
		chk(count_value_o, c0);
		clk_en_i <= 1'b1;
	endtask : t_center
	task automatic results();
		$display("errors %0d compares %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	initial begin
		rst_n_i = 0;
		clk_en_i = 1;
		wr_i = 0;
		rd_i = 0;
		addr_i = 0;
		wdata_i = 0;
		debug_halt_mode_i = 0;
		repeat (12) @(posedge clock_i);
		rst_n_i <= 1'b1;
		tick();
		t_reset();
		t_src();
		t_mod();
		t_ps();
		t_coh();
		t_center();
		results();
	end
endmodule : testbench
